// ---- aeq_ctrl.sv ----
// adaptive equalizer search controller for all receive ports with an axi4-lite register slave
`timescale 1ns/1ps
`default_nettype none
module aeq_ctrl #(
  parameter int NP = 4,
  parameter int AW = 12,
  parameter int unsigned DWELL_CYCLES = aeq_pkg::DWELL_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [NP-1:0] cdr_lock,
  input wire logic [NP-1:0] link_err,
  output logic [NP*aeq_pkg::GAIN_W-1:0] eq_gain,
  output logic [NP-1:0] eq_holding,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import aeq_pkg::*;

  localparam int CW = $clog2(DWELL_CYCLES + 1);
  localparam int PW = (NP > 1) ? $clog2(NP) : 1;

  typedef struct packed {
    aeq_st_t [NP-1:0] st;
    logic [NP-1:0][GAIN_W-1:0] code;
    logic [NP-1:0][CW-1:0] cnt;
    logic [NP-1:0][7:0] errc;
    logic [NP-1:0] first_seen;
    logic [NP-1:0][7:0] ctl;
    logic [NP-1:0][7:0] rng;
    logic [NP-1:0][7:0] thr;
    logic [PW-1:0] psel;
    logic aw_got;
    logic [7:0] aw_idx;
    logic w_got;
    logic [7:0] wdata;
    logic wen;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } aeq_state_t;

  aeq_state_t s_r;
  aeq_state_t s_nxt;

  // per-port helper terms derived from the registered state, then the shared bus write and read decode terms
  logic [NP-1:0][GAIN_W-1:0] start_w;
  logic [NP-1:0][GAIN_W-1:0] ceil_w;
  logic [NP-1:0][GAIN_W-1:0] adv_w;
  logic [NP-1:0][CW-1:0] lim_w;
  logic [NP-1:0] expire_w;
  logic [NP-1:0] half_w;
  logic [NP-1:0] err_hi_w;
  logic [NP-1:0] restart_w;
  logic [NP-1:0][7:0] ctl_eff;
  logic wr_fire;
  logic wr_ctl;
  logic ar_fire;
  logic [7:0] ar_idx;

  // a write is performed once both address and data are held and no response is pending
  assign wr_fire = s_r.aw_got && s_r.w_got && !s_r.bvalid;
  assign wr_ctl = wr_fire && s_r.wen && (s_r.aw_idx == REG_CTL_IDX);
  assign ar_fire = s_axi_arvalid && s_axi_arready;
  assign ar_idx = s_axi_araddr[9:2];

  genvar gp;
  generate
    for (gp = 0; gp < NP; gp++) begin : g_port
      // search starts at floor only when floor enable is set
      // a restarting control write may set floor enable too, so the new value must count at once
      assign ctl_eff[gp] = (wr_ctl && s_r.psel == PW'(gp)) ? s_r.wdata : s_r.ctl[gp];
      assign start_w[gp] = ctl_eff[gp][CTL_FLOOR_EN_BIT] ? s_r.rng[gp][RNG_FLOOR_LSB +: GAIN_W] : '0;
      assign ceil_w[gp] = s_r.rng[gp][RNG_CEIL_LSB +: GAIN_W];
      // past the ceiling wraps back to the start code
      assign adv_w[gp] = (s_r.code[gp] >= ceil_w[gp]) ? start_w[gp] : GAIN_W'(s_r.code[gp] + 1'b1);
      // dwell field halves the dwell per step, zero keeps the full default
      assign lim_w[gp] = CW'(DWELL_CYCLES >> s_r.ctl[gp][CTL_DWELL_LSB +: CTL_DWELL_W]);
      assign expire_w[gp] = (s_r.cnt[gp] >= CW'(lim_w[gp] - 1'b1));
      assign half_w[gp] = (s_r.cnt[gp] == CW'(lim_w[gp] >> 1));
      assign err_hi_w[gp] = s_r.errc[gp] > s_r.thr[gp];
      assign restart_w[gp] = wr_ctl && (s_r.psel == PW'(gp)) && s_r.wdata[CTL_RESTART_BIT];
      assign eq_gain[gp*GAIN_W +: GAIN_W] = s_r.code[gp];
      assign eq_holding[gp] = (s_r.st[gp] == AEQ_HOLD);

      sequence s_dwell_locked;
        s_r.st[gp] == AEQ_WAIT && expire_w[gp] && !half_w[gp] && cdr_lock[gp] && !restart_w[gp];
      endsequence
      sequence s_dwell_unlocked_top;
        s_r.st[gp] == AEQ_WAIT && expire_w[gp] && !(half_w[gp] && err_hi_w[gp]) && !cdr_lock[gp]
          && !restart_w[gp] && s_r.code[gp] >= ceil_w[gp];
      endsequence
      // dwell ran out below the ceiling with no lock and no error burst
      sequence s_dwell_miss;
        s_r.st[gp] == AEQ_WAIT && expire_w[gp] && !(half_w[gp] && err_hi_w[gp]) && !cdr_lock[gp]
          && !restart_w[gp] && s_r.code[gp] < ceil_w[gp];
      endsequence

      a_hold_keeps_code: assert property (@(posedge clk) disable iff (!nrst)
        s_r.st[gp] == AEQ_HOLD && cdr_lock[gp] && !restart_w[gp]
          |=> s_r.st[gp] == AEQ_HOLD && $stable(s_r.code[gp]))
        else $error("held gain code changed while locked");
      a_loss_advances: assert property (@(posedge clk) disable iff (!nrst)
        s_r.st[gp] == AEQ_HOLD && !cdr_lock[gp] && !restart_w[gp]
          |=> s_r.st[gp] == AEQ_WAIT && s_r.code[gp] == $past(adv_w[gp]) && s_r.cnt[gp] == '0)
        else $error("lock loss did not advance the gain code");
      a_dwell_first: assert property (@(posedge clk) disable iff (!nrst)
        s_r.st[gp] == AEQ_WAIT && !expire_w[gp] |=> s_r.st[gp] == AEQ_WAIT)
        else $error("lock judged before dwell expired");
      a_restart_start: assert property (@(posedge clk) disable iff (!nrst)
        restart_w[gp] |=> s_r.code[gp] == $past(start_w[gp]) && s_r.st[gp] == AEQ_WAIT && s_r.cnt[gp] == '0)
        else $error("restart did not return to the start code");
      a_wrap_start: assert property (@(posedge clk) disable iff (!nrst)
        s_dwell_unlocked_top |=> s_r.code[gp] == $past(start_w[gp]))
        else $error("ceiling without lock did not wrap");
      a_lock_holds: assert property (@(posedge clk) disable iff (!nrst)
        s_dwell_locked ##0 (s_r.first_seen[gp] || !s_r.ctl[gp][CTL_FIRST_RST_BIT])
          |=> s_r.st[gp] == AEQ_HOLD && $stable(s_r.code[gp]))
        else $error("locked code not held");
      a_err_raises: assert property (@(posedge clk) disable iff (!nrst)
        s_r.st[gp] == AEQ_WAIT && half_w[gp] && err_hi_w[gp] && !restart_w[gp]
          |=> s_r.code[gp] == $past(adv_w[gp]) && s_r.errc[gp] == '0)
        else $error("error burst did not raise the gain");
      a_status_read: assert property (@(posedge clk) disable iff (!nrst)
        ar_fire && ar_idx == REG_STS_IDX && s_r.psel == PW'(gp)
          |=> s_axi_rvalid && s_axi_rdata[GAIN_W-1:0] == $past(s_r.code[gp]))
        else $error("status read did not return the gain code");
      // the further per-port checks cover the steps that tests reach least often
      // first lock with the restart-once feature on goes back to the start code once
      a_first_restart: assert property (@(posedge clk) disable iff (!nrst)
        s_dwell_locked ##0 (!s_r.first_seen[gp] && s_r.ctl[gp][CTL_FIRST_RST_BIT])
          |=> s_r.first_seen[gp] && s_r.st[gp] == AEQ_WAIT && s_r.code[gp] == $past(start_w[gp]))
        else $error("first lock did not restart the search");
      // a missed dwell below the ceiling steps up by exactly one code
      a_step_up: assert property (@(posedge clk) disable iff (!nrst)
        s_dwell_miss |=> s_r.code[gp] == GAIN_W'($past(s_r.code[gp]) + 1))
        else $error("search did not step to the next code");
      // restart with floor enable clear always begins at code zero
      a_floor_off: assert property (@(posedge clk) disable iff (!nrst)
        restart_w[gp] && !s_r.wdata[CTL_FLOOR_EN_BIT] |=> s_r.code[gp] == '0)
        else $error("restart without floor enable did not begin at zero");
      // status also reports whether the port holds a locked code
      a_status_hold: assert property (@(posedge clk) disable iff (!nrst)
        ar_fire && ar_idx == REG_STS_IDX && s_r.psel == PW'(gp)
          |=> s_axi_rdata[STS_HOLD_BIT] == $past(s_r.st[gp] == AEQ_HOLD))
        else $error("status read did not return the holding flag");
      // every error cycle while searching is counted, saturating at 255, until the judgement points
      a_err_count: assert property (@(posedge clk) disable iff (!nrst)
        s_r.st[gp] == AEQ_WAIT && link_err[gp] && s_r.errc[gp] != 8'hff && !restart_w[gp] && !half_w[gp]
          && !expire_w[gp] |=> s_r.errc[gp] == 8'($past(s_r.errc[gp]) + 1))
        else $error("link error was not counted");
    end
  endgenerate

  // axi handshake outputs; one write and one read held at a time
  assign s_axi_awready = !s_r.aw_got && !s_r.bvalid;
  assign s_axi_wready = !s_r.w_got && !s_r.bvalid;
  assign s_axi_arready = !s_r.rvalid;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;

  // bus-side checks: a read is answered one edge after its address is taken, a write one edge after both halves are held
  a_write_answer: assert property (@(posedge clk) disable iff (!nrst)
    wr_fire |=> s_axi_bvalid)
    else $error("write response missing after both halves");
  a_read_answer: assert property (@(posedge clk) disable iff (!nrst)
    ar_fire |=> s_axi_rvalid)
    else $error("read response missing after address taken");
  // registers are 8 bits wide, the upper read lanes stay zero
  a_rdata_upper: assert property (@(posedge clk) disable iff (!nrst)
    ar_fire |=> s_axi_rdata[31:8] == '0)
    else $error("read data upper lanes not zero");
  // unmapped indices are refused with an error response
  a_bad_index: assert property (@(posedge clk) disable iff (!nrst)
    wr_fire && s_r.aw_idx != REG_CTL_IDX && s_r.aw_idx != REG_STS_IDX && s_r.aw_idx != REG_RNG_IDX
      && s_r.aw_idx != REG_THR_IDX && s_r.aw_idx != REG_PSEL_IDX |=> s_axi_bresp == RESP_SLVERR)
    else $error("unmapped write not refused");

  // next-state logic: bus slave, register updates and per-port search
  always_comb begin
    s_nxt = s_r;
    // write address and data may come in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.aw_idx = s_axi_awaddr[9:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = s_axi_wdata[7:0];
      s_nxt.wen = s_axi_wstrb[0];
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (wr_fire) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = RESP_OKAY;
      // a write without lane 0 stores nothing but is still answered
      unique case (s_r.aw_idx)
        REG_CTL_IDX: begin
          if (s_r.wen) begin
            s_nxt.ctl[s_r.psel] = s_r.wdata & ~8'h01; // restart bit is a strobe and reads back zero
          end
        end
        REG_RNG_IDX: begin
          if (s_r.wen) begin
            s_nxt.rng[s_r.psel] = s_r.wdata;
          end
        end
        REG_THR_IDX: begin
          if (s_r.wen) begin
            s_nxt.thr[s_r.psel] = s_r.wdata;
          end
        end
        REG_PSEL_IDX: begin
          if (s_r.wen) begin
            s_nxt.psel = s_r.wdata[PW-1:0];
          end
        end
        REG_STS_IDX: begin
          s_nxt.bresp = RESP_OKAY; // read-only, writes ignored
        end
        default: begin
          s_nxt.bresp = RESP_SLVERR;
        end
      endcase
    end
    // read path: data registered one cycle after the address is taken
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (ar_fire) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = RESP_OKAY;
      s_nxt.rdata = '0;
      unique case (ar_idx)
        REG_CTL_IDX: s_nxt.rdata[7:0] = s_r.ctl[s_r.psel];
        REG_STS_IDX: s_nxt.rdata[STS_HOLD_BIT:0] = {s_r.st[s_r.psel] == AEQ_HOLD, s_r.code[s_r.psel]};
        REG_RNG_IDX: s_nxt.rdata[7:0] = s_r.rng[s_r.psel];
        REG_THR_IDX: s_nxt.rdata[7:0] = s_r.thr[s_r.psel];
        REG_PSEL_IDX: s_nxt.rdata[PW-1:0] = s_r.psel;
        default: s_nxt.rresp = RESP_SLVERR;
      endcase
    end
    // independent search per receive port
    for (int p = 0; p < NP; p++) begin
      if (restart_w[p]) begin
        s_nxt.st[p] = AEQ_WAIT;
        s_nxt.code[p] = start_w[p];
        s_nxt.cnt[p] = '0;
        s_nxt.errc[p] = '0;
      end else begin
        unique case (s_r.st[p])
          AEQ_WAIT: begin
            s_nxt.cnt[p] = CW'(s_r.cnt[p] + 1'b1);
            if (link_err[p] && s_r.errc[p] != 8'hff) begin
              s_nxt.errc[p] = 8'(s_r.errc[p] + 1'b1);
            end
            if (half_w[p] && err_hi_w[p]) begin
              // too many errors in the first half: raise the gain early
              s_nxt.code[p] = adv_w[p];
              s_nxt.cnt[p] = '0;
              s_nxt.errc[p] = '0;
            end else if (expire_w[p]) begin
              s_nxt.cnt[p] = '0;
              s_nxt.errc[p] = '0;
              if (cdr_lock[p]) begin
                if (s_r.ctl[p][CTL_FIRST_RST_BIT] && !s_r.first_seen[p]) begin
                  // first lock may have come from an arbitrary code, so search once more
                  s_nxt.first_seen[p] = 1'b1;
                  s_nxt.code[p] = start_w[p];
                end else begin
                  s_nxt.st[p] = AEQ_HOLD;
                end
              end else begin
                s_nxt.code[p] = adv_w[p];
              end
            end
          end
          AEQ_HOLD: begin
            if (!cdr_lock[p]) begin
              s_nxt.st[p] = AEQ_WAIT;
              s_nxt.code[p] = adv_w[p];
              s_nxt.cnt[p] = '0;
              s_nxt.errc[p] = '0;
            end
          end
        endcase
      end
    end
  end

  // state register; reset is core digital reset and restarts every search at code zero
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_r <= '0;
      for (int p = 0; p < NP; p++) begin
        s_r.ctl[p] <= CTL_RST;
        s_r.rng[p] <= RNG_RST;
        s_r.thr[p] <= THR_RST;
      end
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule
`default_nettype wire

// ---- aeq_link_model.sv ----
// far-side serializer model: recovery locks only while a port sits on its target gain code
`timescale 1ns/1ps
`default_nettype none
module aeq_link_model #(
  parameter int NP = 4
) (
  input wire logic clk,
  input wire logic [NP*4-1:0] eq_gain,
  input wire logic [NP*4-1:0] target,
  input wire logic [NP-1:0] present,
  input wire logic [NP-1:0] err_burst,
  output logic [NP-1:0] cdr_lock,
  output logic [NP-1:0] link_err
);
  // lock lags the code by one cycle, so a controller judging too early sees no lock
  always_ff @(posedge clk) begin
    for (int p = 0; p < NP; p++) begin
      cdr_lock[p] <= present[p] && (eq_gain[4*p +: 4] == target[4*p +: 4]);
      link_err[p] <= err_burst[p];
    end
  end
endmodule
`default_nettype wire

// ---- aeq_pkg.sv ----
// constants and types shared by the adaptive equalizer search controller
package aeq_pkg;
  // register word indices; byte address is four times the index
  localparam logic [7:0] REG_CTL_IDX = 8'hd2;
  localparam logic [7:0] REG_STS_IDX = 8'hd3;
  localparam logic [7:0] REG_RNG_IDX = 8'hd5;
  localparam logic [7:0] REG_THR_IDX = 8'he0;
  localparam logic [7:0] REG_PSEL_IDX = 8'hf0;
  // equalizer_control fields
  localparam int CTL_RESTART_BIT = 0;
  localparam int CTL_FIRST_RST_BIT = 1;
  localparam int CTL_FLOOR_EN_BIT = 2;
  localparam int CTL_DWELL_LSB = 3;
  localparam int CTL_DWELL_W = 3;
  // equalizer_range_limits fields
  localparam int RNG_FLOOR_LSB = 0;
  localparam int RNG_CEIL_LSB = 4;
  // equalizer_setting_status fields
  localparam int STS_HOLD_BIT = 4;
  localparam int GAIN_W = 4;
  // values after reset
  localparam logic [7:0] CTL_RST = 8'h02;
  localparam logic [7:0] RNG_RST = 8'hf0;
  localparam logic [7:0] THR_RST = 8'h10;
  // dwell per gain code
  localparam int CLK_NS = 20;
  localparam int DWELL_NS = 2620000;
  localparam int DWELL_CYC = (DWELL_NS + CLK_NS - 1) / CLK_NS;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic {AEQ_WAIT, AEQ_HOLD} aeq_st_t;
endpackage

// ---- tb_top.sv ----
// self-checking bench for the adaptive equalizer search controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import aeq_pkg::*;
  localparam int DW = 16;
  logic clk, nrst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [3:0] cdr_lock, link_err, eq_holding, present, err_burst, wstrb;
  logic [15:0] eq_gain, target;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  int failures, total_checks, n, c;
  // short dwell keeps each gain code step to 16 cycles while the dwell field is zero
  aeq_ctrl #(.NP(4), .AW(12), .DWELL_CYCLES(DW)) DUT (.clk(clk), .nrst(nrst), .cdr_lock(cdr_lock),
    .link_err(link_err), .eq_gain(eq_gain), .eq_holding(eq_holding), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  aeq_link_model #(.NP(4)) far_end (.clk(clk), .eq_gain(eq_gain), .target(target), .present(present),
    .err_burst(err_burst), .cdr_lock(cdr_lock), .link_err(link_err));
  task automatic test_done;
    begin
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
        $display("== PASSED ==");
      end else begin
        $display("== FAILED ==");
      end
      $finish;
    end
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      total_checks++;
      if (got !== exp) begin
        failures++;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task automatic hang;
    begin
      failures++;
      test_done();
    end
  endtask
  // ready is sampled at the falling edge; the transfer then lands on the next rising edge
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic a, w, b;
    logic [1:0] r;
    int k;
    begin
      @(posedge clk);
      awaddr <= {2'h0, idx, 2'h0};
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      b = 1'b0;
      k = 0;
      while (!b) begin
        @(negedge clk);
        a = awvalid && awready;
        w = wvalid && wready;
        b = bvalid;
        r = bresp;
        @(posedge clk);
        if (a) awvalid <= 1'b0;
        if (w) wvalid <= 1'b0;
        if (b) bready <= 1'b0;
        k++;
        if (k > 50) hang();
      end
      chk(r, er);
    end
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] er);
    logic a, v;
    logic [31:0] d;
    logic [1:0] r;
    int k;
    begin
      @(posedge clk);
      araddr <= {2'h0, idx, 2'h0};
      arvalid <= 1'b1;
      rready <= 1'b1;
      v = 1'b0;
      k = 0;
      while (!v) begin
        @(negedge clk);
        a = arvalid && arready;
        v = rvalid;
        d = rdata;
        r = rresp;
        @(posedge clk);
        if (a) arvalid <= 1'b0;
        if (v) rready <= 1'b0;
        k++;
        if (k > 50) hang();
      end
      chk(r, er);
      if (er === RESP_OKAY) chk(d, exp);
    end
  endtask
  // counts falling edges until the port's gain code moves
  task automatic wait_chg(input int p, output int cnt);
    logic [3:0] g;
    begin
      g = eq_gain[4*p +: 4];
      cnt = 0;
      do begin
        @(negedge clk);
        cnt++;
        if (cnt > 400) hang();
      end while (eq_gain[4*p +: 4] === g);
    end
  endtask
  task automatic wait_hold(input int p, output int cnt);
    begin
      cnt = 0;
      while (eq_holding[p] !== 1'b1) begin
        @(negedge clk);
        cnt++;
        if (cnt > 400) hang();
      end
    end
  endtask
  // port 1 meets a lock on its first pass: it must restart once, then hold
  task automatic t_first_lock;
    begin
      for (int i = 0; i < 4 && eq_gain[7:4] !== 4'h2; i++) wait_chg(1, n);
      wait_chg(1, n);
      chk(eq_gain[7:4], 4'h0);
      chk(eq_holding[1], 1'b0);
      wait_hold(1, n);
      chk(eq_gain[7:4], 4'h2);
    end
  endtask
  task automatic t_reset;
    begin
      rd(REG_CTL_IDX, {24'h0, CTL_RST}, RESP_OKAY);
      rd(REG_RNG_IDX, {24'h0, RNG_RST}, RESP_OKAY);
      rd(REG_THR_IDX, {24'h0, THR_RST}, RESP_OKAY);
      rd(8'h10, 32'h0, RESP_SLVERR);
      wr(8'h10, 8'h55, RESP_SLVERR);
      wait_chg(3, n);
      chk(n <= DW, 1'b1);
    end
  endtask
  task automatic t_search;
    begin
      @(posedge clk);
      target[3:0] <= 4'h5;
      present[0] <= 1'b1;
      wr(REG_PSEL_IDX, 8'h00, RESP_OKAY);
      wr(REG_CTL_IDX, 8'h01, RESP_OKAY);
      chk(eq_gain[3:0], 4'h0);
      wait_hold(0, n);
      chk(eq_gain[3:0], 4'h5);
      chk(n >= 6*DW-3 && n <= 6*DW+1, 1'b1);
      c = 0;
      repeat (40) begin
        @(negedge clk);
        c += (eq_gain[3:0] !== 4'h5);
      end
      chk(c, 0);
      rd(REG_STS_IDX, 32'h15, RESP_OKAY);
      chk(eq_holding[1], 1'b1);
      @(posedge clk);
      target[3:0] <= 4'h7;
      wait_chg(0, n);
      chk(eq_gain[3:0], 4'h6);
      chk(n <= 3, 1'b1);
      wait_hold(0, n);
      chk(eq_gain[3:0], 4'h7);
    end
  endtask
  // restart from hold into window 3..6 with halved dwell; target 7 lies outside it
  task automatic t_window;
    begin
      wr(REG_RNG_IDX, 8'h63, RESP_OKAY);
      wr(REG_CTL_IDX, 8'h0d, RESP_OKAY);
      chk(eq_gain[3:0], 4'h3);
      for (int k = 0; k < 4; k++) begin
        wait_chg(0, n);
        chk(eq_gain[3:0], (k == 3) ? 4'h3 : 4'(4 + k));
        if (k > 0) chk(n, DW >> 1);
      end
      rd(REG_RNG_IDX, 32'h63, RESP_OKAY);
    end
  endtask
  task automatic t_floor_errors;
    begin
      wr(REG_CTL_IDX, 8'h01, RESP_OKAY);
      chk(eq_gain[3:0], 4'h0);
      wr(REG_THR_IDX, 8'h02, RESP_OKAY);
      wr(REG_CTL_IDX, 8'h01, RESP_OKAY);
      @(posedge clk);
      err_burst[0] <= 1'b1;
      repeat (3) @(posedge clk);
      err_burst[0] <= 1'b0;
      wait_chg(0, n);
      chk(eq_gain[3:0], 4'h1);
      chk(n <= 6, 1'b1);
      chk(eq_holding[1], 1'b1);
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    {nrst, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'h1;
    target = 16'h0020;
    present = 4'b0010;
    err_burst = 4'h0;
    failures = 0;
    total_checks = 0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    t_first_lock();
    t_reset();
    t_search();
    t_window();
    t_floor_errors();
    test_done();
  end
endmodule
`default_nettype wire
